// [logic/rid_decoder.sv]
`timescale 1ns/100ps
// Overview of operation
// - emit points from 1, row-major order
// - mono: width, height, body from byte three
// - mono point is one bit, 1 set
// - colour header: W,H,B,C,offset; body byte seven
// - bits per point one to eight
// - table count zero means 256 entries
// - table offset high byte then low
// - indices taken msb first from body
// - entry n at three bytes each
// - entry bytes are red, green, blue
// - FF full intensity, zero none, linear
// - table reread per image, may be shared
module rid_decoder
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // image file byte source
   output logic rd_req_out,
   output logic [15:0] rd_addr_out,
   input wire logic rd_ack_in,
   input wire logic [7:0] rd_data_in,
   // pixel stream
   output logic pix_valid_out,
   input wire logic pix_ready_in,
   output logic [15:0] pix_num_out,
   output logic pix_on_out,
   output logic [7:0] pix_red_out,
   output logic [7:0] pix_green_out,
   output logic [7:0] pix_blue_out,
   output logic pix_err_out,
   output logic pix_last_out
);
   import rid_pkg::*;

   localparam int ENT_W = 43;

   rid_state_type state_reg;
   rid_state_type ret_reg;
   logic colour_reg;
   logic [15:0] base_reg;
   logic start_reg;
   logic done_reg;
   logic err_reg;
   logic badbpp_reg;
   logic [2:0] hdr_cnt_reg;
   logic [7:0] width_reg;
   logic [7:0] height_reg;
   logic [7:0] bpp_reg;
   logic [7:0] count_raw_reg;
   logic [8:0] ct_count_reg;
   logic [15:0] ct_off_reg;
   logic [15:0] body_addr_reg;
   logic [15:0] points_reg;
   logic [15:0] point_num_reg;
   logic blank_reg;
   logic [7:0] data_reg;
   logic [7:0] shift_reg;
   logic [3:0] bits_left_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] idx_reg;
   logic [1:0] comp_reg;
   logic [7:0] red_reg;
   logic [7:0] green_reg;
   logic [7:0] blue_reg;
   logic on_reg;
   logic pt_err_reg;
   logic rd_req_reg;
   logic [15:0] rd_addr_reg;
   logic [ENT_W-1:0] ent0_reg;
   logic [ENT_W-1:0] ent1_reg;
   logic [1:0] buf_cnt_reg;
   logic [1:0] buf_cnt_next;
   logic valid_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic push;
   logic pop;
   logic [ENT_W-1:0] new_ent;
   logic [7:0] idx_next;
   logic [3:0] need_bits;
   logic [15:0] ct_entry_addr;
   logic apb_do;
   logic [7:0] hdr_len;

   // a bus access completes at the edge where pready is seen high
   assign apb_do = psel_in && penable_in && pready_reg;
   assign hdr_len = {5'h00, colour_reg ? RID_HDR_COLOUR_LEN : RID_HDR_MONO_LEN};
   // the index grows one bit at a time, msb first
   assign idx_next = {idx_reg[6:0], shift_reg[7]};
   assign need_bits = colour_reg ? bpp_reg[3:0] : 4'h1;
   assign ct_entry_addr = ct_off_reg + 16'(RID_CT_ENTRY_BYTES * {2'h0, idx_next});
   assign push = (state_reg == RID_EMIT) && (buf_cnt_reg != 2'h2);
   assign pop = valid_reg && pix_ready_in;
   assign new_ent = {(point_num_reg == points_reg), pt_err_reg, on_reg,
                     red_reg, green_reg, blue_reg, point_num_reg};

   // apb slave: one wait state, then data and pready from flops
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
      else if (psel_in && penable_in && !pready_reg)
      begin
         pready_reg <= 1'b1;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         unique case (paddr_in)
            RID_REG_CTRL: prdata_reg[RID_CTRL_COLOUR_BIT] <= colour_reg;
            RID_REG_BASE: prdata_reg[15:0] <= base_reg;
            RID_REG_STATUS:
            begin
               prdata_reg[RID_STAT_BUSY_BIT] <= (state_reg != RID_IDLE);
               prdata_reg[RID_STAT_DONE_BIT] <= done_reg;
               prdata_reg[RID_STAT_ERR_BIT] <= err_reg;
               prdata_reg[RID_STAT_BADBPP_BIT] <= badbpp_reg;
            end
            RID_REG_GEOM: prdata_reg <= {count_raw_reg, bpp_reg, height_reg, width_reg};
            RID_REG_CTOFF: prdata_reg[15:0] <= ct_off_reg;
            RID_REG_POINTS: prdata_reg[15:0] <= point_num_reg;
            default: pslverr_reg <= 1'b1; // unmapped: reads zero, flags error
         endcase
      end
      else
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // software writes; start is a one-cycle pulse, ignored while busy
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         colour_reg <= RID_COLOUR_RESET;
         base_reg <= RID_BASE_RESET;
         start_reg <= 1'b0;
      end
      else
      begin
         start_reg <= 1'b0;
         if (apb_do && pwrite_in && paddr_in == RID_REG_CTRL && state_reg == RID_IDLE)
         begin
            colour_reg <= pwdata_in[RID_CTRL_COLOUR_BIT];
            start_reg <= pwdata_in[RID_CTRL_START_BIT];
         end
         if (apb_do && pwrite_in && paddr_in == RID_REG_BASE && state_reg == RID_IDLE)
            base_reg <= pwdata_in[15:0];
      end
   end

   // sequencer: header, bit unpacking, table lookup, emit
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= RID_IDLE;
         ret_reg <= RID_IDLE;
         rd_req_reg <= 1'b0;
         rd_addr_reg <= 16'h0000;
         hdr_cnt_reg <= 3'h0;
         width_reg <= 8'h00;
         height_reg <= 8'h00;
         bpp_reg <= 8'h00;
         count_raw_reg <= 8'h00;
         ct_count_reg <= 9'h000;
         ct_off_reg <= 16'h0000;
         body_addr_reg <= 16'h0000;
         points_reg <= 16'h0000;
         point_num_reg <= RID_FIRST_POINT;
         blank_reg <= 1'b0;
         data_reg <= 8'h00;
         shift_reg <= 8'h00;
         bits_left_reg <= 4'h0;
         bit_cnt_reg <= 4'h0;
         idx_reg <= 8'h00;
         comp_reg <= 2'h0;
         red_reg <= 8'h00;
         green_reg <= 8'h00;
         blue_reg <= 8'h00;
         on_reg <= 1'b0;
         pt_err_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         badbpp_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            RID_IDLE:
            begin
               if (start_reg)
               begin
                  // table offset is reread every image, so sharing is safe
                  done_reg <= 1'b0;
                  err_reg <= 1'b0;
                  badbpp_reg <= 1'b0;
                  blank_reg <= 1'b0;
                  hdr_cnt_reg <= 3'h0;
                  point_num_reg <= RID_FIRST_POINT;
                  rd_req_reg <= 1'b1;
                  rd_addr_reg <= base_reg;
                  ret_reg <= RID_HDR;
                  state_reg <= RID_READ;
               end
            end
            RID_READ:
            begin
               if (rd_req_reg && rd_ack_in)
               begin
                  rd_req_reg <= 1'b0;
                  if (ret_reg == RID_BIT)
                  begin
                     shift_reg <= rd_data_in;
                     bits_left_reg <= RID_BYTE_BITS;
                  end
                  else
                     data_reg <= rd_data_in;
                  state_reg <= ret_reg;
               end
            end
            RID_HDR:
            begin
               unique case (hdr_cnt_reg)
                  RID_HDR_WIDTH: width_reg <= data_reg;
                  RID_HDR_HEIGHT: height_reg <= data_reg;
                  RID_HDR_BPP: bpp_reg <= data_reg;
                  RID_HDR_COUNT: count_raw_reg <= data_reg;
                  RID_HDR_CT_HI: ct_off_reg[15:8] <= data_reg;
                  RID_HDR_CT_LO: ct_off_reg[7:0] <= data_reg;
                  default: ;
               endcase
               if ({5'h00, hdr_cnt_reg} == hdr_len - 8'h01)
               begin
                  body_addr_reg <= base_reg + {8'h00, hdr_len};
                  state_reg <= RID_CHECK;
               end
               else
               begin
                  hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
                  rd_req_reg <= 1'b1;
                  rd_addr_reg <= base_reg + {13'h0000, hdr_cnt_reg} + 16'h0001;
                  state_reg <= RID_READ;
               end
            end
            RID_CHECK:
            begin
               points_reg <= {8'h00, width_reg} * {8'h00, height_reg};
               // a zero count stands for a full table
               ct_count_reg <= (count_raw_reg == 8'h00) ? RID_CT_ZERO_COUNT
                                                        : {1'b0, count_raw_reg};
               bits_left_reg <= 4'h0;
               bit_cnt_reg <= 4'h0;
               idx_reg <= 8'h00;
               if (width_reg == 8'h00 || height_reg == 8'h00)
                  state_reg <= RID_DONE;
               else if (colour_reg && (bpp_reg < RID_BPP_MIN || bpp_reg > RID_BPP_MAX))
               begin
                  // body cannot be parsed: every point goes out black
                  blank_reg <= 1'b1;
                  badbpp_reg <= 1'b1;
                  err_reg <= 1'b1;
                  pt_err_reg <= 1'b1;
                  on_reg <= 1'b0;
                  red_reg <= RID_NO_INTENSITY;
                  green_reg <= RID_NO_INTENSITY;
                  blue_reg <= RID_NO_INTENSITY;
                  state_reg <= RID_EMIT;
               end
               else
                  state_reg <= RID_BIT;
            end
            RID_BIT:
            begin
               if (bits_left_reg == 4'h0)
               begin
                  // no row padding: the next point continues in the next byte
                  rd_req_reg <= 1'b1;
                  rd_addr_reg <= body_addr_reg;
                  body_addr_reg <= body_addr_reg + 16'h0001;
                  ret_reg <= RID_BIT;
                  state_reg <= RID_READ;
               end
               else
               begin
                  shift_reg <= {shift_reg[6:0], 1'b1};
                  bits_left_reg <= bits_left_reg - 4'h1;
                  if (bit_cnt_reg + 4'h1 == need_bits)
                  begin
                     // trailing pad bits are never reached after the last point
                     bit_cnt_reg <= 4'h0;
                     idx_reg <= 8'h00;
                     pt_err_reg <= 1'b0;
                     if (!colour_reg)
                     begin
                        on_reg <= shift_reg[7];
                        red_reg <= shift_reg[7] ? RID_FULL_INTENSITY : RID_NO_INTENSITY;
                        green_reg <= shift_reg[7] ? RID_FULL_INTENSITY : RID_NO_INTENSITY;
                        blue_reg <= shift_reg[7] ? RID_FULL_INTENSITY : RID_NO_INTENSITY;
                        state_reg <= RID_EMIT;
                     end
                     else if ({1'b0, idx_next} >= ct_count_reg)
                     begin
                        err_reg <= 1'b1;
                        pt_err_reg <= 1'b1;
                        on_reg <= 1'b0;
                        red_reg <= RID_NO_INTENSITY;
                        green_reg <= RID_NO_INTENSITY;
                        blue_reg <= RID_NO_INTENSITY;
                        state_reg <= RID_EMIT;
                     end
                     else
                     begin
                        on_reg <= 1'b1;
                        comp_reg <= 2'h0;
                        rd_req_reg <= 1'b1;
                        rd_addr_reg <= ct_entry_addr;
                        ret_reg <= RID_LOOK;
                        state_reg <= RID_READ;
                     end
                  end
                  else
                  begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     idx_reg <= idx_next;
                  end
               end
            end
            RID_LOOK:
            begin
               // intensities pass through unchanged, already linear
               unique case (comp_reg)
                  2'h0: red_reg <= data_reg;
                  2'h1: green_reg <= data_reg;
                  default: blue_reg <= data_reg;
               endcase
               if (comp_reg == RID_CT_LAST_COMP)
                  state_reg <= RID_EMIT;
               else
               begin
                  comp_reg <= comp_reg + 2'h1;
                  rd_req_reg <= 1'b1;
                  rd_addr_reg <= rd_addr_reg + 16'h0001;
                  ret_reg <= RID_LOOK;
                  state_reg <= RID_READ;
               end
            end
            RID_EMIT:
            begin
               if (push)
               begin
                  if (point_num_reg == points_reg)
                     state_reg <= RID_DONE;
                  else
                  begin
                     point_num_reg <= point_num_reg + 16'h0001;
                     state_reg <= blank_reg ? RID_EMIT : RID_BIT;
                  end
               end
            end
            RID_DONE:
            begin
               done_reg <= 1'b1;
               state_reg <= RID_IDLE;
            end
         endcase
      end
   end

   // two-entry output buffer; ent0 is the head and drives the pins
   always_comb
   begin
      buf_cnt_next = buf_cnt_reg;
      if (push && !pop)
         buf_cnt_next = buf_cnt_reg + 2'h1;
      else if (pop && !push)
         buf_cnt_next = buf_cnt_reg - 2'h1;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ent0_reg <= '0;
         ent1_reg <= '0;
         buf_cnt_reg <= 2'h0;
         valid_reg <= 1'b0;
      end
      else
      begin
         buf_cnt_reg <= buf_cnt_next;
         valid_reg <= (buf_cnt_next != 2'h0);
         if (push && !pop)
         begin
            if (buf_cnt_reg == 2'h0)
               ent0_reg <= new_ent;
            else
               ent1_reg <= new_ent;
         end
         else if (pop && !push)
            ent0_reg <= ent1_reg;
         else if (pop && push)
         begin
            if (buf_cnt_reg == 2'h1)
               ent0_reg <= new_ent;
            else
            begin
               ent0_reg <= ent1_reg;
               ent1_reg <= new_ent;
            end
         end
      end
   end

   // outputs come straight from flops
   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;
   assign rd_req_out = rd_req_reg;
   assign rd_addr_out = rd_addr_reg;
   assign pix_valid_out = valid_reg;
   assign pix_last_out = ent0_reg[42];
   assign pix_err_out = ent0_reg[41];
   assign pix_on_out = ent0_reg[40];
   assign pix_red_out = ent0_reg[39:32];
   assign pix_green_out = ent0_reg[31:24];
   assign pix_blue_out = ent0_reg[23:16];
   assign pix_num_out = ent0_reg[15:0];

   // helper: number of the last point handed over
   logic [15:0] last_pop_num;
   logic pop_seen;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         last_pop_num <= 16'h0000;
         pop_seen <= 1'b0;
      end
      else if (state_reg == RID_CHECK)
         pop_seen <= 1'b0;
      else if (pop)
      begin
         last_pop_num <= pix_num_out;
         pop_seen <= !pix_last_out;
      end
   end

   sequence body_byte_fetched;
      state_reg == RID_READ && rd_req_reg && rd_ack_in && ret_reg == RID_BIT;
   endsequence

   sequence msb_taken;
      bits_left_reg == RID_BYTE_BITS && state_reg == RID_BIT ##1 bits_left_reg == 4'h7
      && shift_reg[7] == $past(shift_reg[6]);
   endsequence

   raster_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
      pop && pop_seen |-> pix_num_out == last_pop_num + 16'h0001)
      else $error("points not emitted in raster order");

   mono_body_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == RID_CHECK && !colour_reg |-> body_addr_reg == base_reg + 16'h0002)
      else $error("mono body does not start at byte three");

   colour_body_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == RID_CHECK && colour_reg |-> body_addr_reg == base_reg + 16'h0006)
      else $error("colour body does not start at byte seven");

   bad_bpp_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == RID_CHECK && colour_reg && width_reg != 8'h00 && height_reg != 8'h00
      && (bpp_reg == 8'h00 || bpp_reg > 8'h08) |=> blank_reg && err_reg)
      else $error("out of range bits per point not flagged");

   zero_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == RID_CHECK && count_raw_reg == 8'h00 |=> ct_count_reg == 9'h100)
      else $error("zero table count not read as 256");

   table_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg == RID_BIT && $past(state_reg) == RID_BIT && ret_reg != RID_LOOK ##1
      state_reg == RID_READ && ret_reg == RID_LOOK && comp_reg == 2'h0
      |-> rd_addr_reg == ct_off_reg + 16'(10'h003 * {2'h0, $past(idx_next)}))
      else $error("colour table entry address wrong");

   msb_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
      body_byte_fetched |=> msb_taken)
      else $error("body byte not consumed msb first");

   err_black_a: assert property (@(posedge clk_in) disable iff (rst_in)
      valid_reg && pix_err_out |-> pix_red_out == 8'h00 && pix_green_out == 8'h00
      && pix_blue_out == 8'h00)
      else $error("error point not black");

   mono_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
      valid_reg && !colour_reg |-> pix_red_out == (pix_on_out ? 8'hFF : 8'h00))
      else $error("mono point level wrong");

   stall_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      valid_reg && !pix_ready_in |=> valid_reg && $stable(pix_num_out))
      else $error("stalled point lost or changed");
endmodule

// [logic/rid_pkg.sv]
package rid_pkg;
   // register offsets on the apb port (byte addresses)
   localparam logic [7:0] RID_REG_CTRL = 8'h00;
   localparam logic [7:0] RID_REG_BASE = 8'h04;
   localparam logic [7:0] RID_REG_STATUS = 8'h08;
   localparam logic [7:0] RID_REG_GEOM = 8'h0C;
   localparam logic [7:0] RID_REG_CTOFF = 8'h10;
   localparam logic [7:0] RID_REG_POINTS = 8'h14;
   // control register fields
   localparam int RID_CTRL_START_BIT = 0;
   localparam int RID_CTRL_COLOUR_BIT = 1;
   // status register fields
   localparam int RID_STAT_BUSY_BIT = 0;
   localparam int RID_STAT_DONE_BIT = 1;
   localparam int RID_STAT_ERR_BIT = 2;
   localparam int RID_STAT_BADBPP_BIT = 3;
   // values after reset
   localparam logic [15:0] RID_BASE_RESET = 16'h0000;
   localparam logic RID_COLOUR_RESET = 1'b0;
   // header layout: byte counts before the body
   localparam logic [2:0] RID_HDR_MONO_LEN = 3'h2;
   localparam logic [2:0] RID_HDR_COLOUR_LEN = 3'h6;
   localparam logic [2:0] RID_HDR_WIDTH = 3'h0;
   localparam logic [2:0] RID_HDR_HEIGHT = 3'h1;
   localparam logic [2:0] RID_HDR_BPP = 3'h2;
   localparam logic [2:0] RID_HDR_COUNT = 3'h3;
   localparam logic [2:0] RID_HDR_CT_HI = 3'h4;
   localparam logic [2:0] RID_HDR_CT_LO = 3'h5;
   // bits per point range and colour table coding
   localparam logic [7:0] RID_BPP_MIN = 8'h01;
   localparam logic [7:0] RID_BPP_MAX = 8'h08;
   localparam logic [8:0] RID_CT_ZERO_COUNT = 9'h100;
   localparam logic [9:0] RID_CT_ENTRY_BYTES = 10'h003;
   localparam logic [1:0] RID_CT_LAST_COMP = 2'h2;
   localparam logic [3:0] RID_BYTE_BITS = 4'h8;
   localparam logic [7:0] RID_FULL_INTENSITY = 8'hFF;
   localparam logic [7:0] RID_NO_INTENSITY = 8'h00;
   localparam logic [15:0] RID_FIRST_POINT = 16'h0001;
   // sequencer states
   typedef enum logic [2:0] {
      RID_IDLE = 3'b000,
      RID_READ = 3'b001,
      RID_HDR = 3'b010,
      RID_CHECK = 3'b011,
      RID_BIT = 3'b100,
      RID_LOOK = 3'b101,
      RID_EMIT = 3'b110,
      RID_DONE = 3'b111
   } rid_state_type;
endpackage

// [bench/rid_byte_source.sv]
`timescale 1ns/100ps
// image file model: one read at a time, answered after a random wait
module rid_byte_source
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // read port
   input wire logic rd_req_in,
   input wire logic [15:0] rd_addr_in,
   output logic rd_ack_out,
   output logic [7:0] rd_data_out
);
   logic [7:0] mem [0:65535]; // filled by the bench, last body byte padded with ones
   int seed = 5;
   int wait_cnt;
   // data is only good with ack; otherwise it toggles, or holds while a read waits, so a stale byte never matches
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_ack_out <= 1'b0;
         rd_data_out <= 8'h00;
         wait_cnt <= 0;
      end
      else if (rd_ack_out || !rd_req_in)
      begin
         rd_ack_out <= 1'b0;
         rd_data_out <= ~rd_data_out;
      end
      else if (wait_cnt == 0)
      begin
         rd_ack_out <= 1'b1;
         rd_data_out <= mem[rd_addr_in];
         wait_cnt <= {$random(seed)} % 4;
      end
      else
         wait_cnt <= wait_cnt - 1;
   end
endmodule

// [bench/raster_image_decoder_test.sv]
`timescale 1ns/100ps
module raster_image_decoder_test;
   import rid_pkg::*;
   logic clk_in, rst_in, psel, penable, pwrite, pix_ready, pready, pslverr, rd_req, rd_ack;
   logic pix_valid, pix_on, pix_err, pix_last, e;
   logic [7:0] paddr, rd_data, red, grn, blu;
   logic [15:0] rd_addr, pix_num;
   logic [31:0] pwdata, prdata, r;
   int n_errors = 0, checks_done = 0, seed = 82119, b, c;
   // free-running clock
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   rid_decoder u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
      .rd_ack_in(rd_ack), .rd_data_in(rd_data), .pix_valid_out(pix_valid),
      .pix_ready_in(pix_ready), .pix_num_out(pix_num), .pix_on_out(pix_on),
      .pix_red_out(red), .pix_green_out(grn), .pix_blue_out(blu), .pix_err_out(pix_err),
      .pix_last_out(pix_last));
   rid_byte_source u_src (.clk_in(clk_in), .rst_in(rst_in), .rd_req_in(rd_req),
      .rd_addr_in(rd_addr), .rd_ack_out(rd_ack), .rd_data_out(rd_data));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one apb transfer; a registered pready is read at the very edge that samples it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_in);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         print_verdict;
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // body field of n bits at bit position pos, msb first, bytes back to back
   function automatic logic [7:0] field(int body, int pos, int n);
      logic [7:0] v = 8'h00;
      for (int i = 0; i < n; i++)
         v = {v[6:0], u_src.mem[body + (pos + i) / 8][7 - (pos + i) % 8]};
      return v;
   endfunction
   task run(input logic col, input int base, input int w, input int h, input int bpp,
      input int cnt, input int ct);
      int body, bb, nbits, k, g, idx, cn;
      logic bad, eon, eerr, anyerr;
      logic [23:0] rgb;
      body = base + (col ? 6 : 2);
      bad = col && (bpp < 1 || bpp > 8);
      bb = col ? bpp : 1;
      nbits = bad ? 0 : w * h * bb;
      cn = (cnt == 0) ? 256 : cnt;
      {u_src.mem[base], u_src.mem[base + 1], u_src.mem[base + 2]} = {w[7:0], h[7:0], bpp[7:0]};
      {u_src.mem[base + 3], u_src.mem[base + 4], u_src.mem[base + 5]} = {cnt[7:0], ct[15:0]};
      for (int i = 0; i < (nbits + 7) / 8; i++)
         u_src.mem[body + i] = $random(seed);
      for (int i = nbits; i % 8 != 0; i++)
         u_src.mem[body + i / 8][7 - i % 8] = 1'b1;
      apb(1'b1, RID_REG_BASE, base);
      apb(1'b1, RID_REG_CTRL, {30'h0, col, 1'b1});
      k = 0;
      g = 0;
      anyerr = 1'b0;
      while (k < w * h && g < 20000)
      begin
         @(negedge clk_in);
         g++;
         if (pix_valid === 1'b1 && pix_ready === 1'b1)
         begin
            idx = bad ? 0 : field(body, k * bb, bb);
            eerr = col && (bad || idx >= cn);
            eon = col ? !eerr : idx[0];
            rgb = !col ? {24{eon}} : eerr ? 24'h0 : {u_src.mem[ct + 3 * idx],
               u_src.mem[ct + 3 * idx + 1], u_src.mem[ct + 3 * idx + 2]};
            anyerr |= eerr;
            chk(pix_num, k + 1);
            chk({pix_on, pix_err}, {eon, eerr});
            chk({red, grn, blu}, rgb);
            chk(pix_last, k == w * h - 1);
            k++;
         end
      end
      if (k < w * h)
      begin
         n_errors++;
         print_verdict;
      end
      g = 0;
      apb(1'b0, RID_REG_STATUS, 0);
      while (r[RID_STAT_DONE_BIT] !== 1'b1 && g < 200)
      begin
         apb(1'b0, RID_REG_STATUS, 0);
         g++;
      end
      if (g >= 200)
      begin
         n_errors++;
         print_verdict;
      end
      chk({r[RID_STAT_BUSY_BIT], r[RID_STAT_ERR_BIT], r[RID_STAT_BADBPP_BIT]},
         {1'b0, anyerr, bad});
      apb(1'b0, RID_REG_POINTS, 0);
      chk(r[15:0], w * h);
      if (col)
      begin
         apb(1'b0, RID_REG_GEOM, 0);
         chk(r, {cnt[7:0], bpp[7:0], h[7:0], w[7:0]});
         apb(1'b0, RID_REG_CTOFF, 0);
         chk(r[15:0], ct);
      end
      $display("image done: colour %0d bpp %0d points %0d", col, bpp, k);
   endtask
   // consumer stalls at random
   always @(posedge clk_in)
      pix_ready <= ($random(seed) & 1) != 0;
   initial
   begin
      #400000;
      n_errors++;
      print_verdict;
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rst_in = 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      apb(1'b0, RID_REG_BASE, 0);
      chk(r, {16'h0, RID_BASE_RESET});
      chk(e, 1'b0);
      apb(1'b0, RID_REG_CTRL, 0);
      chk(r[RID_CTRL_COLOUR_BIT], RID_COLOUR_RESET);
      apb(1'b0, 8'h40, 0);
      chk(e, 1'b1);
      chk(r, 32'h0);
      for (int i = 0; i < 768; i++)
         u_src.mem[16'h4000 + i] = $random(seed);
      for (int t = 0; t < 3; t++)
         run(1'b0, 16'h0100, 1 + {$random(seed)} % 8, 1 + {$random(seed)} % 8, 0, 0, 0);
      for (b = 1; b <= 8; b++)
      begin
         c = (b == 8) ? 0 : 1 + {$random(seed)} % (1 << b);
         // every image points at the same table
         run(1'b1, 16'h0100 * b, 1 + {$random(seed)} % 8, 1 + {$random(seed)} % 8, b, c,
            16'h4000);
      end
      run(1'b1, 16'h1000, 2, 2, 0, 1, 16'h4000);
      run(1'b1, 16'h1100, 3, 1, 9, 1, 16'h4000);
      print_verdict;
   end
endmodule
